// File: core/nsov_pkg.sv
package nsov_pkg;
    // clock and the millisecond base of the delay timer
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // register byte offsets on the apb slave
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LEVEL = 8'h04;
    localparam logic [7:0] OFF_DELAY = 8'h08;
    localparam logic [7:0] OFF_STATE = 8'h0c;
    localparam logic [7:0] OFF_INT_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h14;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h18;
    localparam logic [7:0] OFF_MEAS = 8'h1c;
    // field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_START_ONLY_BIT = 1;
    localparam int EV_START_BIT = 0;
    localparam int EV_TRIP_BIT = 1;
    // setting ranges and defaults
    localparam logic [15:0] LEVEL_MIN = 16'h0002;
    localparam logic [15:0] LEVEL_MAX = 16'h0028;
    localparam logic [5:0] LEVEL_RST = 6'h1e;
    localparam logic [15:0] DELAY_MIN = 16'h0032;
    localparam logic [15:0] DELAY_MAX = 16'hea60;
    localparam logic [15:0] DELAY_RST = 16'h0064;
    localparam logic ENABLE_RST = 1'b1;
    localparam logic START_ONLY_RST = 1'b0;
    // measured input is in hundredths of a percent
    localparam logic [15:0] RMS_PER_PCT = 16'h0064;

    // settings steering the function
    typedef struct packed {
        logic enable;
        logic start_only;
        logic [5:0] level;
        logic [15:0] delay;
    } nsov_cfg_t;

    // event and status pair
    typedef struct packed {
        logic trip;
        logic start;
    } nsov_ev_t;
endpackage

// File: core/nsov_timer.sv
// Function
// - start asserts while voltage exceeds threshold
// - threshold percent setting 2 to 40, default 30
// - delay ms setting 50 to 60000, default 100
// - delay counts only while above threshold
// - trip needs expired delay and trip mode
// - disable setting or blocking input suppresses operation
// - internal start and delayed trip status outputs
// - start-only flag, default false, inhibits trip
// - general start and trip gated by blocking
`timescale 1ns/100ps
module nsov_timer
    import nsov_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] neg_seq_rms,
    input wire logic block_in,
    output logic start_status,
    output logic trip_status,
    output logic general_start_out,
    output logic general_trip_out,
    output logic irq
);
    localparam int DIV_W = $clog2(MS_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYC - 1);

    nsov_cfg_t cfg; // software settings
    nsov_ev_t int_status; // sticky event bits
    nsov_ev_t int_enable; // interrupt mask, high enables
    nsov_ev_t events; // one-cycle rising edges of the general outputs
    logic [DIV_W-1:0] div_cnt; // cycles inside the current millisecond
    logic ms_tick; // one-cycle pulse per elapsed millisecond
    logic [15:0] ms_count; // elapsed whole milliseconds above threshold
    logic [15:0] thresh; // threshold in input units
    logic above; // measured voltage over the threshold
    logic run; // function enabled and not blocked
    logic setup; // apb setup phase
    logic wr_en; // apb write completes this edge
    logic mapped; // address hits a register

    // clamp a written value into its legal range
    function automatic logic [15:0] clamp(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction

    // comparison and enable terms; upstream rms is taken as is
    assign thresh = 16'(cfg.level) * RMS_PER_PCT;
    assign above = neg_seq_rms > thresh;
    assign run = cfg.enable && !block_in;
    assign ms_tick = (div_cnt == DIV_LAST);

    // apb decode: zero wait states, answer in the access cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    always_comb
    begin
        case (paddr)
            OFF_CTRL, OFF_LEVEL, OFF_DELAY, OFF_STATE,
            OFF_INT_STATUS, OFF_INT_CLEAR, OFF_INT_ENABLE,
            OFF_MEAS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // pready rises for exactly the access cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
        end
    end

    // read data captured at setup; clear register reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0;
        end
        else if (setup)
        begin
            case (paddr)
                OFF_CTRL: prdata <= {30'h0, cfg.start_only, cfg.enable};
                OFF_LEVEL: prdata <= {26'h0, cfg.level};
                OFF_DELAY: prdata <= {16'h0, cfg.delay};
                OFF_STATE: prdata <= {28'h0, general_trip_out,
                                      general_start_out, trip_status,
                                      start_status};
                OFF_INT_STATUS: prdata <= {30'h0, int_status};
                OFF_INT_ENABLE: prdata <= {30'h0, int_enable};
                OFF_MEAS: prdata <= {16'h0, ms_count};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // settings; out-of-range writes are clamped, never refused
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg.enable <= ENABLE_RST;
            cfg.start_only <= START_ONLY_RST;
            cfg.level <= LEVEL_RST;
            cfg.delay <= DELAY_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                OFF_CTRL:
                begin
                    cfg.enable <= pwdata[CTRL_ENABLE_BIT];
                    cfg.start_only <= pwdata[CTRL_START_ONLY_BIT];
                end
                OFF_LEVEL:
                    cfg.level <= 6'(clamp(pwdata[15:0], LEVEL_MIN,
                                          LEVEL_MAX));
                OFF_DELAY:
                    cfg.delay <= clamp(pwdata[15:0], DELAY_MIN,
                                       DELAY_MAX);
                default:
                    cfg <= cfg;
            endcase
        end
    end

    // millisecond divider, restarted whenever timing stops so each
    // timed interval starts on a fresh millisecond
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= '0;
        end
        else if (!(run && above) || ms_tick)
        begin
            div_cnt <= '0;
        end
        else
        begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    // elapsed delay; saturates so a long hold never wraps to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_count <= 16'h0;
        end
        else if (!(run && above))
        begin
            ms_count <= 16'h0;
        end
        else if (ms_tick && ms_count != 16'hffff)
        begin
            ms_count <= ms_count + 16'h1;
        end
    end

    // internal start and trip status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_status <= 1'b0;
            trip_status <= 1'b0;
        end
        else
        begin
            start_status <= run && above;
            trip_status <= run && above && !cfg.start_only
                           && (ms_count >= cfg.delay);
        end
    end

    // general outputs, gated once more by the blocking input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            general_start_out <= 1'b0;
            general_trip_out <= 1'b0;
        end
        else
        begin
            general_start_out <= start_status && !block_in;
            general_trip_out <= trip_status && !block_in;
        end
    end

    // interrupt: rising edges of general outputs set sticky bits
    assign events.start = !general_start_out && start_status && !block_in;
    assign events.trip = !general_trip_out && trip_status && !block_in;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_status <= '0;
            int_enable <= '0;
        end
        else
        begin
            // a new event beats a clear in the same cycle
            if (wr_en && paddr == OFF_INT_CLEAR)
            begin
                int_status <= (int_status & ~nsov_ev_t'(pwdata[1:0]))
                              | events;
            end
            else
            begin
                int_status <= int_status | events;
            end
            if (wr_en && paddr == OFF_INT_ENABLE)
            begin
                int_enable <= nsov_ev_t'(pwdata[1:0]);
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(int_status & int_enable);
        end
    end

    property p_start_follows;
        @(posedge pclk) disable iff (!presetn)
        (run && above) |=> start_status;
    endproperty
    a_start_follows: assert property (p_start_follows)
        else $error("start missing while above threshold");

    property p_level_range;
        @(posedge pclk) disable iff (!presetn)
        (16'(cfg.level) >= LEVEL_MIN) && (16'(cfg.level) <= LEVEL_MAX);
    endproperty
    a_level_range: assert property (p_level_range)
        else $error("threshold setting out of range");

    property p_delay_range;
        @(posedge pclk) disable iff (!presetn)
        (cfg.delay >= DELAY_MIN) && (cfg.delay <= DELAY_MAX);
    endproperty
    a_delay_range: assert property (p_delay_range)
        else $error("delay setting out of range");

    property p_count_needs_above;
        @(posedge pclk) disable iff (!presetn)
        (ms_count != 16'h0 && ms_count != $past(ms_count))
            |-> $past(run && above && ms_tick);
    endproperty
    a_count_needs_above: assert property (p_count_needs_above)
        else $error("delay advanced without overvoltage");

    property p_trip_cause;
        @(posedge pclk) disable iff (!presetn)
        trip_status |-> $past(ms_count >= cfg.delay && !cfg.start_only);
    endproperty
    a_trip_cause: assert property (p_trip_cause)
        else $error("trip before delay expiry or in start mode");

    property p_block_suppress;
        @(posedge pclk) disable iff (!presetn)
        (block_in || !cfg.enable) |=> !start_status && !trip_status;
    endproperty
    a_block_suppress: assert property (p_block_suppress)
        else $error("operation while disabled or blocked");

    property p_trip_with_start;
        @(posedge pclk) disable iff (!presetn)
        trip_status |-> start_status;
    endproperty
    a_trip_with_start: assert property (p_trip_with_start)
        else $error("trip status without start status");

    property p_start_only;
        @(posedge pclk) disable iff (!presetn)
        cfg.start_only |=> !trip_status;
    endproperty
    a_start_only: assert property (p_start_only)
        else $error("trip issued in start-only mode");

    property p_general_gate;
        @(posedge pclk) disable iff (!presetn)
        general_trip_out |-> $past(trip_status && !block_in);
    endproperty
    a_general_gate: assert property (p_general_gate)
        else $error("general trip not gated by blocking");

    property p_drop_clears;
        @(posedge pclk) disable iff (!presetn)
        !(run && above) |=> (ms_count == 16'h0) ##1 !general_start_out;
    endproperty
    a_drop_clears: assert property (p_drop_clears)
        else $error("timer or outputs not cleared on drop");
endmodule

// File: verif/nsov_src_model.sv
`timescale 1ns/100ps
// upstream sequence calculation and user blocking logic, as seen by the block
module nsov_src_model
    import nsov_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] want_rms,
    input wire logic want_block,
    output logic [15:0] neg_seq_rms,
    output logic block_in
);
    // new rms value once per protection cycle, like a real calculation
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            neg_seq_rms <= 16'h0000;
        end
        else
        begin
            neg_seq_rms <= want_rms;
        end
    end

    // user blocking equation output, registered like any graphic logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            block_in <= 1'b0;
        end
        else
        begin
            block_in <= want_block;
        end
    end
endmodule

// File: verif/testbench.sv
`timescale 1ns/100ps
module testbench
    import nsov_pkg::*;
;
    localparam int MSC = 4; // short millisecond so delays stay cheap
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] want_rms, neg_seq_rms;
    logic want_block, block_in, err;
    logic start_status, trip_status, general_start_out, general_trip_out;
    int mismatches, checks, n;
    // clamp table: address, written value, value read back
    // the last delay write leaves the 50 ms minimum for the trip test
    logic [7:0] ca[4] = '{OFF_LEVEL, OFF_LEVEL, OFF_DELAY, OFF_DELAY};
    logic [31:0] cw[4] = '{32'h1, 32'h29, 32'hea61, 32'h31};
    logic [31:0] ce[4] = '{32'h2, 32'h28, 32'hea60, 32'h32};

    nsov_src_model src (.pclk(pclk), .presetn(presetn),
        .want_rms(want_rms), .want_block(want_block),
        .neg_seq_rms(neg_seq_rms), .block_in(block_in));

    nsov_timer #(.MS_CYC(MSC)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .neg_seq_rms(neg_seq_rms), .block_in(block_in),
        .start_status(start_status), .trip_status(trip_status),
        .general_start_out(general_start_out),
        .general_trip_out(general_trip_out), .irq(irq));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // one verdict, reached by the tests or by the watchdog
    task summarize();
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one apb transfer; waits for pready, never assumes a latency
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // watchdog: the whole sequence needs about 700 cycles
    initial
    begin
        cyc(20000);
        mismatches++;
        summarize();
    end

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, want_block} = '0;
        paddr = '0;
        pwdata = '0;
        want_rms = '0;
        cyc(20);
        presetn <= 1'b1;
        rdchk(OFF_CTRL, 32'h1);
        rdchk(OFF_LEVEL, 32'h1e);
        rdchk(OFF_DELAY, 32'h64);
        rdchk(OFF_INT_ENABLE, 32'h0);
        rdchk(8'h20, 32'h0);
        chk(32'(err), 32'h1);
        // out-of-range settings are clamped, not refused
        for (int i = 0; i < 4; i++)
        begin
            xfer(ca[i], 1'b1, cw[i]);
            rdchk(ca[i], ce[i]);
        end
        xfer(OFF_LEVEL, 1'b1, 32'h1e);
        xfer(OFF_INT_ENABLE, 1'b1, 32'h3);
        // exactly at the threshold is not above it
        want_rms <= 16'h0bb8;
        cyc(8);
        chk(32'(start_status), 32'h0);
        want_rms <= 16'h0bb9;
        cyc(5);
        chk(32'(start_status), 32'h1);
        chk(32'(general_start_out), 32'h1);
        // short dip restarts the delay from zero
        cyc(100);
        want_rms <= 16'h0000;
        cyc(4);
        chk(32'(start_status), 32'h0);
        rdchk(OFF_MEAS, 32'h0);
        want_rms <= 16'h0bb9;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (trip_status !== 1'b1 && n < 400);
        chk(32'(n >= 198 && n <= 206), 32'h1);
        cyc(2);
        chk(32'(general_trip_out), 32'h1);
        // all four status lines high while tripped
        rdchk(OFF_STATE, 32'hf);
        rdchk(OFF_INT_STATUS, 32'h3);
        chk(32'(irq), 32'h1);
        xfer(OFF_INT_CLEAR, 1'b1, 32'h3);
        rdchk(OFF_INT_STATUS, 32'h0);
        cyc(2);
        chk(32'(irq), 32'h0);
        // blocking input silences everything
        want_block <= 1'b1;
        cyc(4);
        chk(32'(start_status), 32'h0);
        chk(32'(general_start_out), 32'h0);
        chk(32'(general_trip_out), 32'h0);
        want_rms <= 16'h0000;
        cyc(2);
        want_block <= 1'b0;
        // disable setting silences everything
        xfer(OFF_CTRL, 1'b1, 32'h0);
        want_rms <= 16'h0bb9;
        cyc(10);
        chk(32'(start_status), 32'h0);
        xfer(OFF_INT_ENABLE, 1'b1, 32'h0);
        // start only: no trip however long the voltage stays high
        xfer(OFF_CTRL, 1'b1, 32'h3);
        cyc(260);
        chk(32'(start_status), 32'h1);
        chk(32'(trip_status), 32'h0);
        chk(32'(general_trip_out), 32'h0);
        rdchk(OFF_INT_STATUS, 32'h1);
        chk(32'(irq), 32'h0);
        want_rms <= 16'h0000;
        cyc(4);
        summarize();
    end
endmodule
